// >>> scs_spi_top.sv
/*
 * SPI controller: APB register file, shift engine, flags, interrupts.
 * Assumes pins are synchronous to pclk and that SCK from a master has
 * high and low phases of more than two pclk cycles.
 */
// Design decision made here: the APB interface to the registers.
//
// Behaviour
// - master SCK is pclk divided by 4/16/64/128, or 2/8/32/64 doubled.
// - a nonzero irq level enables the request, raised while TC is set.
// - TC flag sets when a whole byte has shifted in and out.
// - TC flag also sets when a master sees its slave-select input low.
// - TC flag clears when the processor takes the SPI vector.
// - TC flag clears on a data access after a flags read that saw it.
// - write-collision flag sets on a data write during a transfer.
// - write-collision flag clears on a data access after a flags read.
// - writing the data register starts shifting that byte out.
// - reading the data register returns the last complete byte.
// - bit order control selects lsb first when one, msb first when zero.
// - mode field sets SCK idle level and which edge samples or sets up.
// - slave-select low on a master whose ss pin is an input drops it back to slave mode.
// - slave-select high on a slave resets shifting and drops the byte.
`timescale 1ns/10ps
`default_nettype none
module scs_spi_top (
	input wire logic pclk, // peripheral clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [scs_pkg::ADDR_W-1:0] paddr, // apb byte address
	input wire logic [scs_pkg::DATA_W-1:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [scs_pkg::DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic sck_i, // sck pin level
	output logic sck_o, // sck drive value
	output logic sck_oe, // sck drive enable
	input wire logic mosi_i, // mosi pin level
	output logic mosi_o, // mosi drive value
	output logic mosi_oe, // mosi drive enable
	input wire logic miso_i, // miso pin level
	output logic miso_o, // miso drive value
	output logic miso_oe, // miso drive enable
	input wire logic ss_n_i, // slave select, low
	input wire logic ss_is_input, // ss pin configured as input
	input wire logic irq_vector_ack, // spi vector taken, pulse
	output logic spi_irq_req, // leveled request to controller
	output logic [1:0] spi_irq_level, // request priority level
	output logic irq // masked event interrupt
);
	import scs_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	scs_ctrl_t ctrl_reg, ctrl_next, ctrl_wr;
	logic [1:0] irq_level_sel_reg, irq_level_sel_next;
	logic tc_flag_reg, tc_flag_next, wc_flag_reg, wc_flag_next;
	logic arm_tc_reg, arm_tc_next, arm_wc_reg, arm_wc_next;
	logic [7:0] sh_reg, sh_next, sh_shift, rx_buf_reg, rx_buf_next;
	scs_state_t state_reg, state_next;
	logic [3:0] edge_cnt_reg, edge_cnt_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic sck_reg, sck_next, out_bit_reg, out_bit_next, sck_prev_reg;
	logic [EVT_W-1:0] evt_status_reg, evt_status_next, evt_set;
	logic [EVT_W-1:0] evt_enable_reg, evt_enable_next, evt_clr;
	logic [DATA_W-1:0] prdata_reg;
	logic pready_reg, pslverr_reg, irq_reg, spi_irq_req_reg;
	logic sck_oe_reg, mosi_oe_reg, miso_oe_reg;
	logic [1:0] spi_irq_level_reg;
	logic [7:0] flags_w, rd_mux;

	// apb decode; zero wait states, so access phase is the taking edge
	logic setup_ph, acc_ph, aligned, hit, wr, rd;
	logic [5:0] idx;
	assign setup_ph = psel && !penable;
	assign acc_ph = psel && penable;
	assign idx = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign hit = aligned && (idx <= IDX_EVT_ENABLE);
	assign wr = acc_ph && pwrite && hit && pstrb[0];
	assign rd = acc_ph && !pwrite && hit;
	logic wr_ctrl, wr_irqc, wr_data, wr_clr, wr_en, rd_flags, rd_data;
	logic data_acc;
	assign wr_ctrl = wr && (idx == IDX_CONTROL);
	assign wr_irqc = wr && (idx == IDX_IRQ_CONTROL);
	assign wr_data = wr && (idx == IDX_SHIFT_DATA);
	assign wr_clr = wr && (idx == IDX_EVT_CLEAR);
	assign wr_en = wr && (idx == IDX_EVT_ENABLE);
	assign rd_flags = rd && (idx == IDX_FLAGS);
	assign rd_data = rd && (idx == IDX_SHIFT_DATA);
	assign data_acc = wr_data || rd_data;

	// shift engine decode
	logic cpha, cpol, is_master, is_slave, fault, slave_reset, busy;
	logic tick, m_edge, s_edge, any_edge, lead, sample, setup, in_bit;
	logic first_bit, start_m, load_s, s_start, m_done, s_done, done;
	assign cpha = ctrl_reg.mode[0];
	assign cpol = ctrl_reg.mode[1];
	assign is_master = ctrl_reg.enable && ctrl_reg.master;
	assign is_slave = ctrl_reg.enable && !ctrl_reg.master;
	assign busy = (state_reg == ST_SHIFT);
	assign fault = is_master && ss_is_input && !ss_n_i;
	assign slave_reset = is_slave && ss_n_i;
	assign start_m = wr_data && is_master && !busy && !fault;
	assign load_s = wr_data && !busy && !is_master;
	assign m_edge = busy && is_master && tick;
	// pins are synchronous, so a plain previous-level compare is safe
	assign s_edge = is_slave && !ss_n_i && (sck_i != sck_prev_reg);
	assign any_edge = m_edge || s_edge;
	assign lead = is_master ? !edge_cnt_reg[0] : (sck_i != cpol);
	assign sample = any_edge && (lead != cpha);
	assign setup = any_edge && (lead == cpha);
	assign in_bit = ctrl_reg.master ? miso_i : mosi_i;
	assign sh_shift = ctrl_reg.bit_order_sel ?
		{in_bit, sh_reg[7:1]} : {sh_reg[6:0], in_bit};
	assign first_bit = ctrl_reg.bit_order_sel ? sh_reg[0] : sh_reg[7];
	assign s_start = s_edge && lead && !busy;
	assign m_done = m_edge && (edge_cnt_reg == EDGES_LAST);
	assign s_done = sample && is_slave && busy && (bit_cnt_reg == BITS_LAST);
	assign done = m_done || s_done;

	scs_sck_div u_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(busy && is_master),
		.ctrl(ctrl_reg),
		.tick(tick)
	);

	// next-state of the shift engine
	assign state_next = (done || fault || slave_reset) ? ST_IDLE :
		(start_m || s_start) ? ST_SHIFT : state_reg;
	assign edge_cnt_next = (!busy || start_m) ? 4'h0 :
		m_edge ? edge_cnt_reg + 4'h1 : edge_cnt_reg;
	assign bit_cnt_next = (!busy && !s_start) || slave_reset ? 3'h0 :
		sample ? bit_cnt_reg + 3'h1 : bit_cnt_reg;
	assign sh_next = (start_m || load_s) ? pwdata[7:0] :
		(sample && !slave_reset) ? sh_shift : sh_reg;
	assign rx_buf_next = done ? (sample ? sh_shift : sh_reg) :
		rx_buf_reg;
	assign out_bit_next = (start_m || load_s) ?
		(ctrl_reg.bit_order_sel ? pwdata[0] : pwdata[7]) :
		(setup || !busy) ? first_bit : out_bit_reg;
	// idle level follows polarity; toggles once per tick in a transfer
	assign sck_next = (busy && is_master && !fault) ?
		(m_edge ? !sck_reg : sck_reg) : cpol;

	// control, irq level, flags
	assign ctrl_wr = wr_ctrl ? scs_ctrl_t'(pwdata[7:0]) : ctrl_reg;
	always_comb begin
		ctrl_next = ctrl_wr;
		if (fault) begin
			ctrl_next.master = 1'b0;
		end
	end
	assign irq_level_sel_next = wr_irqc ? pwdata[1:0] : irq_level_sel_reg;
	logic tc_set, tc_clr, wc_set, wc_clr;
	assign tc_set = done || fault;
	assign tc_clr = irq_vector_ack || (arm_tc_reg && data_acc);
	assign wc_set = wr_data && busy;
	assign wc_clr = arm_wc_reg && data_acc;
	// a new event in the clearing cycle survives
	assign tc_flag_next = tc_set || (tc_flag_reg && !tc_clr);
	assign wc_flag_next = wc_set || (wc_flag_reg && !wc_clr);
	assign arm_tc_next = rd_flags ? tc_flag_reg :
		data_acc ? 1'b0 : arm_tc_reg;
	assign arm_wc_next = rd_flags ? wc_flag_reg :
		data_acc ? 1'b0 : arm_wc_reg;

	// sticky events, write-one clear; set beats clear
	assign evt_set[EVT_TC] = done;
	assign evt_set[EVT_WC] = wc_set;
	assign evt_set[EVT_FAULT] = fault;
	assign evt_clr = wr_clr ? pwdata[EVT_W-1:0] : '0;
	assign evt_status_next = evt_set | (evt_status_reg & ~evt_clr);
	assign evt_enable_next = wr_en ? pwdata[EVT_W-1:0] : evt_enable_reg;

	// read mux, captured in the setup cycle
	always_comb begin
		flags_w = 8'h00;
		flags_w[FLAG_TC_BIT] = tc_flag_reg;
		flags_w[FLAG_WC_BIT] = wc_flag_reg;
	end
	assign rd_mux = !hit ? 8'h00 :
		(idx == IDX_CONTROL) ? ctrl_reg :
		(idx == IDX_IRQ_CONTROL) ? {6'h00, irq_level_sel_reg} :
		(idx == IDX_FLAGS) ? flags_w :
		(idx == IDX_SHIFT_DATA) ? rx_buf_reg :
		(idx == IDX_EVT_STATUS) ? {5'h00, evt_status_reg} :
		(idx == IDX_EVT_ENABLE) ? {5'h00, evt_enable_reg} : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			edge_cnt_reg <= 4'h0;
			bit_cnt_reg <= 3'h0;
			sh_reg <= DATA_RST;
			rx_buf_reg <= DATA_RST;
			out_bit_reg <= 1'b0;
			sck_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			edge_cnt_reg <= edge_cnt_next;
			bit_cnt_reg <= bit_cnt_next;
			sh_reg <= sh_next;
			rx_buf_reg <= rx_buf_next;
			out_bit_reg <= out_bit_next;
			sck_reg <= sck_next;
			sck_prev_reg <= sck_i;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CONTROL_RST;
			irq_level_sel_reg <= IRQ_CONTROL_RST;
			tc_flag_reg <= 1'b0;
			wc_flag_reg <= 1'b0;
			arm_tc_reg <= 1'b0;
			arm_wc_reg <= 1'b0;
			evt_status_reg <= '0;
			evt_enable_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			irq_level_sel_reg <= irq_level_sel_next;
			tc_flag_reg <= tc_flag_next;
			wc_flag_reg <= wc_flag_next;
			arm_tc_reg <= arm_tc_next;
			arm_wc_reg <= arm_wc_next;
			evt_status_reg <= evt_status_next;
			evt_enable_reg <= evt_enable_next;
		end
	end

	// outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
			spi_irq_req_reg <= 1'b0;
			spi_irq_level_reg <= IRQ_CONTROL_RST;
			sck_oe_reg <= 1'b0;
			mosi_oe_reg <= 1'b0;
			miso_oe_reg <= 1'b0;
		end else begin
			if (setup_ph) begin
				prdata_reg <= {24'h000000, rd_mux};
				pslverr_reg <= !hit;
			end else if (!psel) begin
				pslverr_reg <= 1'b0;
			end
			pready_reg <= 1'b1;
			irq_reg <= |(evt_status_next & evt_enable_next);
			spi_irq_req_reg <= tc_flag_next &&
				(irq_level_sel_next != IRQ_CONTROL_RST);
			spi_irq_level_reg <= irq_level_sel_next;
			sck_oe_reg <= ctrl_next.enable && ctrl_next.master;
			mosi_oe_reg <= ctrl_next.enable && ctrl_next.master;
			// slave drives miso only while selected
			miso_oe_reg <= ctrl_next.enable && !ctrl_next.master && !ss_n_i;
		end
	end
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign spi_irq_req = spi_irq_req_reg;
	assign spi_irq_level = spi_irq_level_reg;
	assign sck_o = sck_reg;
	assign sck_oe = sck_oe_reg;
	assign mosi_o = out_bit_reg;
	assign mosi_oe = mosi_oe_reg;
	assign miso_o = out_bit_reg;
	assign miso_oe = miso_oe_reg;

	sequence s_status_seen;
		rd_flags && tc_flag_reg;
	endsequence
	sequence s_data_touch;
		data_acc && !tc_set;
	endsequence
	property p_tc_seq_clear;
		s_status_seen ##[2:3] s_data_touch |=> !tc_flag_reg;
	endproperty
	a_tc_seq_clear: assert property (p_tc_seq_clear)
		else $error("tc flag survived status read and data access");
	property p_irq_req;
		(tc_flag_reg && irq_level_sel_reg != IRQ_CONTROL_RST) |-> spi_irq_req;
	endproperty
	a_irq_req: assert property (p_irq_req)
		else $error("enabled spi request missing while tc set");
	property p_tc_set;
		done |=> tc_flag_reg ##0 rx_buf_reg == $past(rx_buf_next);
	endproperty
	a_tc_set: assert property (p_tc_set)
		else $error("byte completion did not set tc");
	property p_fault;
		fault |=> (tc_flag_reg && !ctrl_reg.master && !busy);
	endproperty
	a_fault: assert property (p_fault)
		else $error("mode fault did not drop master and set tc");
	property p_vec_clear;
		(irq_vector_ack && !tc_set) |=> !tc_flag_reg;
	endproperty
	a_vec_clear: assert property (p_vec_clear)
		else $error("vector ack did not clear tc");
	property p_wc_set;
		(wr_data && busy && !sample) |=> wc_flag_reg && $stable(sh_reg);
	endproperty
	a_wc_set: assert property (p_wc_set)
		else $error("collision write not flagged or data altered");
	property p_wc_hold;
		(wc_flag_reg && !(arm_wc_reg && data_acc)) |=> wc_flag_reg;
	endproperty
	a_wc_hold: assert property (p_wc_hold)
		else $error("write collision cleared without sequence");
	property p_ss_abort;
		slave_reset |=> (state_reg == ST_IDLE && bit_cnt_reg == 3'h0);
	endproperty
	a_ss_abort: assert property (p_ss_abort)
		else $error("slave shift logic not reset by deselect");
	property p_start;
		start_m |=> busy ##0 sh_reg == $past(pwdata[7:0]);
	endproperty
	a_start: assert property (p_start)
		else $error("data write did not start transfer");
	property p_irq_out;
		irq == |(evt_status_reg & evt_enable_reg);
	endproperty
	a_irq_out: assert property (p_irq_out)
		else $error("irq does not follow enabled status");
endmodule // scs_spi_top
`default_nettype wire

// >>> scs_pkg.sv
/*
 * Shared constants and types for the SPI controller register block:
 * register indices, control layout, flag positions, divider table.
 * Assumes a 32-bit APB slave where register index n sits at byte 4*n.
 */
`default_nettype none
package scs_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CONTROL = 6'h00;
	localparam logic [5:0] IDX_IRQ_CONTROL = 6'h01;
	localparam logic [5:0] IDX_FLAGS = 6'h02;
	localparam logic [5:0] IDX_SHIFT_DATA = 6'h03;
	localparam logic [5:0] IDX_EVT_STATUS = 6'h04;
	localparam logic [5:0] IDX_EVT_CLEAR = 6'h05;
	localparam logic [5:0] IDX_EVT_ENABLE = 6'h06;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [1:0] IRQ_CONTROL_RST = 2'h0;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam int FLAG_TC_BIT = 7;
	localparam int FLAG_WC_BIT = 6;
	// sticky event bits
	localparam int EVT_TC = 0;
	localparam int EVT_WC = 1;
	localparam int EVT_FAULT = 2;
	localparam int EVT_W = 3;
	localparam logic [3:0] EDGES_LAST = 4'hf;
	localparam logic [2:0] BITS_LAST = 3'h7;
	// half period minus one, indexed by {clock_double, prescaler}
	localparam logic [5:0] HALF_M1_TAB [0:7] = '{
		6'h01, 6'h07, 6'h1f, 6'h3f, 6'h00, 6'h03, 6'h0f, 6'h1f};
	typedef struct packed {
		logic clock_double;
		logic enable;
		logic bit_order_sel;
		logic master;
		logic [1:0] mode;
		logic [1:0] prescaler;
	} scs_ctrl_t;
	typedef enum logic {ST_IDLE, ST_SHIFT} scs_state_t;
endpackage
`default_nettype wire

// >>> scs_sck_div.sv
/*
 * Serial clock rate generator: one-cycle tick per half SCK period.
 * Assumes the caller holds run high for the whole master transfer.
 */
`timescale 1ns/10ps
`default_nettype none
module scs_sck_div (
	input wire logic pclk, // peripheral clock
	input wire logic presetn, // async reset, low
	input wire logic run, // count while high
	input wire scs_pkg::scs_ctrl_t ctrl, // rate selection
	output logic tick // half-period pulse
);
	import scs_pkg::*;
	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;
	logic tick_reg;
	logic [5:0] half_m1;
	logic wrap;
	assign half_m1 = HALF_M1_TAB[{ctrl.clock_double, ctrl.prescaler}];
	assign wrap = (cnt_reg >= half_m1);
	assign cnt_next = (!run || wrap) ? 6'h00 : cnt_reg + 6'h01;
	assign tick = tick_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 6'h00;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= run && wrap;
		end
	end
	// gap between ticks, checked only when the rate setting held still
	logic [5:0] gap_reg;
	logic seen_reg;
	scs_ctrl_t ctrl_prev_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_reg <= 6'h00;
			seen_reg <= 1'b0;
			ctrl_prev_reg <= CONTROL_RST;
		end else begin
			gap_reg <= tick_reg ? 6'h00 : gap_reg + 6'h01;
			seen_reg <= tick_reg || (seen_reg && run && ctrl == ctrl_prev_reg);
			ctrl_prev_reg <= ctrl;
		end
	end
	property p_div_gap;
		@(posedge pclk) disable iff (!presetn)
		(tick_reg && seen_reg && run && ctrl == ctrl_prev_reg)
			|-> gap_reg == half_m1;
	endproperty
	a_div_gap: assert property (p_div_gap)
		else $error("sck half period does not match rate setting");
endmodule // scs_sck_div
`default_nettype wire

// >>> scs_slave_model.sv
/* SPI slave model on the far side of a master transfer.
   Assumes sck comes from the design and the bench drives cs_n. */
`timescale 1ns/10ps
`default_nettype none
module scs_slave_model (
	input wire logic cs_n, // select, low
	input wire logic sck, // serial clock
	input wire logic mosi, // data from master
	input wire logic [1:0] mode, // transfer mode
	input wire logic lsb_first, // bit order
	input wire logic [7:0] tx, // byte to send
	output logic miso, // data to master
	output logic [7:0] rx // bits taken in
);
	int oi = 0;
	logic last = 1'b0;
	always @(negedge cs_n) begin
		oi = mode[0] ? -1 : 0;
	end
	// level compare inline: a separate wire could lag the sck event
	always @(sck) begin
		if (!cs_n && ((sck != mode[1]) ^ mode[0]))
			rx = lsb_first ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		else if (!cs_n)
			oi = oi + 1;
	end
	// released line shows the inverse of its last bit
	always @(*) begin
		if (!cs_n && oi >= 0 && oi < 8) begin
			miso = lsb_first ? tx[oi] : tx[7-oi];
			last = miso;
		end else
			miso = ~last;
	end
endmodule // scs_slave_model
`default_nettype wire

// >>> tb.sv
/* Self-checking bench for the SPI register block over APB.
   Assumes scs_pkg and the slave model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import scs_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic miso_o, miso_oe, spi_irq_req, irq, err, s_miso, slsb = 1'b0;
	logic ss_n_i = 1'b1, ss_is_input = 1'b0, irq_vector_ack = 1'b0;
	logic sck_m = 1'b0, mosi_m = 1'b0, cs_n = 1'b1;
	logic [1:0] spi_irq_level, smode = 2'h0;
	logic [7:0] stx = 8'h00, s_rx, mb, got;
	int bad_count = 0, cmp_count = 0, cyc = 0, n;
	int unsigned dv [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
	// shared wires: each party drives only while its enable is high
	wire sck_w = sck_oe ? sck_o : sck_m;
	wire mosi_w = mosi_oe ? mosi_o : mosi_m;
	wire miso_w = miso_oe ? miso_o : s_miso;
	scs_spi_top scs_spi_top_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
		.mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
		.ss_n_i(ss_n_i), .ss_is_input(ss_is_input),
		.irq_vector_ack(irq_vector_ack), .spi_irq_req(spi_irq_req),
		.spi_irq_level(spi_irq_level), .irq(irq));
	scs_slave_model scs_slave_model_inst (.cs_n(cs_n), .sck(sck_o),
		.mosi(mosi_o), .mode(smode), .lsb_first(slsb), .tx(stx),
		.miso(s_miso), .rx(s_rx));
	initial forever #2.5 pclk = ~pclk;
	task end_of_test;
		$display("TB: counts cmp=%0d bad=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count = bad_count + 1;
			end_of_test();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [5:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rc(input logic [5:0] i, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		chk(rd, {24'h0, e});
	endtask
	// polls the event register so the flags stay unarmed
	task wait_done;
		n = 0;
		rd = 32'h0;
		while (rd[0] !== 1'b1 && n < 600) begin
			apb(1'b0, IDX_EVT_STATUS, 8'h00);
			n++;
		end
		chk(32'(irq), 32'h1);
		apb(1'b1, IDX_EVT_CLEAR, 8'h01);
		@(posedge pclk);
		chk(32'(irq), 32'h0);
	endtask
	// bench as mode 0 master, msb first, slow enough for the previous-level edge compare
	task sm(input logic [7:0] b, input int nb);
		ss_n_i <= 1'b0;
		for (int j = 0; j < nb; j++) begin
			mosi_m <= b[7-j];
			repeat (4) @(posedge pclk);
			sck_m <= 1'b1;
			got = {got[6:0], miso_w};
			repeat (4) @(posedge pclk);
			sck_m <= 1'b0;
		end
		repeat (4) @(posedge pclk);
		mosi_m <= ~mosi_m;
		ss_n_i <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rc(IDX_CONTROL, CONTROL_RST);
		rc(IDX_IRQ_CONTROL, 8'h00);
		apb(1'b1, IDX_FLAGS, 8'hff);
		rc(IDX_FLAGS, 8'h00);
		rc(IDX_EVT_STATUS, 8'h00);
		rc(6'h3f, 8'h00);
		chk(32'(err), 32'h1);
		apb(1'b1, IDX_EVT_ENABLE, 8'h01);
		rc(IDX_EVT_ENABLE, 8'h01);
		$display("test reset_map done");
		for (int k = 0; k < 8; k++) begin
			mb = 8'ha5 ^ 8'(k * 37);
			smode <= k[1:0];
			slsb <= k[0];
			stx <= ~mb;
			apb(1'b1, IDX_CONTROL, {k[2], 1'b1, k[0], 1'b1, k[1:0], k[1:0]});
			apb(1'b1, IDX_IRQ_CONTROL, {6'h0, k[1:0]});
			@(posedge pclk);
			chk(32'(sck_o), 32'(k[1]));
			chk(32'(spi_irq_level), 32'(k[1:0]));
			cs_n <= 1'b0;
			apb(1'b1, IDX_SHIFT_DATA, mb);
			n = 0;
			while (sck_o === k[1] && n < 300) begin
				@(posedge pclk);
				n++;
			end
			n = 0;
			while (sck_o !== k[1] && n < 300) begin
				@(posedge pclk);
				n++;
			end
			chk(32'(n), 32'(dv[k]));
			wait_done();
			cs_n <= 1'b1;
			chk(32'(s_rx), 32'(mb));
			chk(32'(sck_o), 32'(k[1]));
			chk(32'(spi_irq_req), 32'(k[1:0] != 2'h0));
			rc(IDX_FLAGS, 8'h80);
			rc(IDX_SHIFT_DATA, ~mb);
			rc(IDX_FLAGS, 8'h00);
		end
		$display("test master_rates done");
		apb(1'b1, IDX_CONTROL, 8'h53);
		apb(1'b1, IDX_IRQ_CONTROL, 8'h02);
		smode <= 2'h0;
		slsb <= 1'b0;
		stx <= 8'h3c;
		cs_n <= 1'b0;
		apb(1'b1, IDX_SHIFT_DATA, 8'h11);
		apb(1'b1, IDX_SHIFT_DATA, 8'h22);
		rc(IDX_EVT_STATUS, 8'h02);
		chk(32'(irq), 32'h0);
		wait_done();
		chk(32'(s_rx), 32'h11);
		apb(1'b1, IDX_EVT_CLEAR, 8'h02);
		rc(IDX_SHIFT_DATA, 8'h3c);
		cs_n <= 1'b1;
		rc(IDX_FLAGS, 8'hc0);
		cs_n <= 1'b0;
		apb(1'b1, IDX_SHIFT_DATA, 8'h44);
		rc(IDX_FLAGS, 8'h00);
		wait_done();
		chk(32'(s_rx), 32'h44);
		chk(32'(spi_irq_req), 32'h1);
		irq_vector_ack <= 1'b1;
		@(posedge pclk);
		irq_vector_ack <= 1'b0;
		rc(IDX_FLAGS, 8'h00);
		chk(32'(spi_irq_req), 32'h0);
		cs_n <= 1'b1;
		$display("test collision done");
		apb(1'b1, IDX_CONTROL, 8'h50);
		ss_is_input <= 1'b1;
		ss_n_i <= 1'b0;
		repeat (4) @(posedge pclk);
		rc(IDX_FLAGS, 8'h80);
		rc(IDX_CONTROL, 8'h40);
		apb(1'b0, IDX_EVT_STATUS, 8'h00);
		chk(32'(rd[2]), 32'h1);
		ss_n_i <= 1'b1;
		ss_is_input <= 1'b0;
		rc(IDX_SHIFT_DATA, 8'h3c);
		apb(1'b1, IDX_EVT_CLEAR, 8'h07);
		$display("test mode_fault done");
		apb(1'b1, IDX_SHIFT_DATA, 8'hc7);
		sm(8'hff, 3);
		apb(1'b1, IDX_SHIFT_DATA, 8'h96);
		sm(8'h5a, 8);
		chk(32'(got), 32'h96);
		wait_done();
		rc(IDX_SHIFT_DATA, 8'h5a);
		$display("test slave done");
		end_of_test();
	end
endmodule // tb
`default_nettype wire
